//--- bstp_test_port.sv
// Boundary-scan test access port sampled on the system clock
`timescale 1ns/1ps
// Summary of operation
// - The instruction register is ten bits and shifts between TDI and TDO in instruction scans.
// - USERCODE puts the 32-bit user code register between TDI and TDO.
// - SAMPLE/PRELOAD captures pin levels while the core runs and accepts a pattern for later.
// - EXTEST drives outputs from the chain update stage and captures input pin levels.
// - BYPASS puts a one-bit register between TDI and TDO while the core runs normally.
// - CLAMP holds pins from the update stage and routes TDI to TDO through the bypass bit.
// - IDCODE puts the identification register between TDI and TDO.
// - The boundary chain length is a per-variant parameter such as 96, 192 or 288.
// - The identification value is version, part number, manufacturer and one trailing bit.
// - The identification value always ends in a one.
// - Programming instructions are accepted through the test port.
// - With the scan interface disabled, the four test pins are released as user pins.
// - Entering and leaving programming mode each take one millisecond.
// - A bulk erase instruction starts a single 100 ms erase pulse.
module bstp_test_port #(
    parameter int BSR_LEN = bstp_pkg::BSR_DEFAULT,
    parameter int SWITCH_CYC = bstp_pkg::PROG_SWITCH_CYC,
    parameter int ERASE_CYCLES = bstp_pkg::ERASE_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic scanEnable,
    input wire bstp_pkg::bstp_pins_t pins,
    input wire logic [31:0] userCode,
    input wire logic [BSR_LEN-1:0] pinIn,
    input wire logic [BSR_LEN-1:0] coreOut,
    output logic tdo,
    output logic tdoOe,
    output logic pinsReleased,
    output logic [BSR_LEN-1:0] pinOut,
    output logic progMode,
    output logic progBusy,
    output logic eraseActive
);
    import bstp_pkg::*;

    localparam int DW = (BSR_LEN > 32) ? BSR_LEN : 32;
    localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFG, 1'b1};

    logic [2:0] s1, s2, s3, filt;
    logic tckPrev;
    logic [BSR_LEN-1:0] pin1, pin2, pin3, pinLevel;
    bstp_state_t state;
    logic [IR_LEN-1:0] irShift, irReg;
    logic [DW-1:0] dr;
    logic [BSR_LEN-1:0] bsrUpd;
    logic [31:0] timer;
    logic switching;
    bstp_pins_t fp;
    logic tckRise, tckFall, tmsV, tdiV;

    // Instructions that put the boundary chain between TDI and TDO
    function automatic logic selBoundary(input logic [IR_LEN-1:0] op);
        selBoundary = (op == OP_SAMPLE) || (op == OP_EXTEST);
    endfunction : selBoundary

    function automatic int drLen(input logic [IR_LEN-1:0] op);
        if (selBoundary(op)) begin
            drLen = BSR_LEN;
        end else if (op == OP_IDCODE) begin
            drLen = ID_LEN;
        end else if (op == OP_USERCODE) begin
            drLen = UC_LEN;
        end else begin
            drLen = 1;
        end
    endfunction : drLen

    assign fp = bstp_pins_t'(filt);
    assign tckRise = fp.tck && !tckPrev;
    assign tckFall = !fp.tck && tckPrev;
    assign tmsV = fp.tms;
    assign tdiV = fp.tdi;

    // Three-stage synchroniser; a bit changes once stages two and three agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1 <= SYNC_RESET;
            s2 <= SYNC_RESET;
            s3 <= SYNC_RESET;
            filt <= SYNC_RESET;
            tckPrev <= 1'b0;
        end else if (ce) begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            filt <= (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
            tckPrev <= fp.tck;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin1 <= '0;
            pin2 <= '0;
            pin3 <= '0;
            pinLevel <= '0;
        end else if (ce) begin
            // Pin levels pass the same three-stage filter as the link pins
            pin1 <= pinIn;
            pin2 <= pin1;
            pin3 <= pin2;
            pinLevel <= (pin2 & ~(pin2 ^ pin3)) | (pinLevel & (pin2 ^ pin3));
        end
    end

    // Controller state
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_RESET;
        end else if (ce) begin
            if (!scanEnable) begin
                state <= ST_RESET;
            end else if (tckRise) begin
                case (state)
                    ST_RESET: state <= tmsV ? ST_RESET : ST_IDLE;
                    ST_IDLE: state <= tmsV ? ST_SEL_DR : ST_IDLE;
                    ST_SEL_DR: state <= tmsV ? ST_SEL_IR : ST_CAP_DR;
                    ST_CAP_DR: state <= tmsV ? ST_EX1_DR : ST_SHF_DR;
                    ST_SHF_DR: state <= tmsV ? ST_EX1_DR : ST_SHF_DR;
                    ST_EX1_DR: state <= tmsV ? ST_UPD_DR : ST_PAU_DR;
                    ST_PAU_DR: state <= tmsV ? ST_EX2_DR : ST_PAU_DR;
                    ST_EX2_DR: state <= tmsV ? ST_UPD_DR : ST_SHF_DR;
                    ST_UPD_DR: state <= tmsV ? ST_SEL_DR : ST_IDLE;
                    ST_SEL_IR: state <= tmsV ? ST_RESET : ST_CAP_IR;
                    ST_CAP_IR: state <= tmsV ? ST_EX1_IR : ST_SHF_IR;
                    ST_SHF_IR: state <= tmsV ? ST_EX1_IR : ST_SHF_IR;
                    ST_EX1_IR: state <= tmsV ? ST_UPD_IR : ST_PAU_IR;
                    ST_PAU_IR: state <= tmsV ? ST_EX2_IR : ST_PAU_IR;
                    ST_EX2_IR: state <= tmsV ? ST_UPD_IR : ST_SHF_IR;
                    default: state <= tmsV ? ST_SEL_DR : ST_IDLE;
                endcase
            end
        end
    end

    // Instruction register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irShift <= '0;
            irReg <= OP_IDCODE;
        end else if (ce) begin
            if (state == ST_RESET) begin
                irReg <= OP_IDCODE;
            end else if (tckRise) begin
                if (state == ST_CAP_IR) begin
                    irShift <= IR_CAPTURE;
                end else if (state == ST_SHF_IR) begin
                    irShift <= {tdiV, irShift[IR_LEN-1:1]};
                end else if (state == ST_UPD_IR) begin
                    irReg <= irShift;
                end
            end
        end
    end

    // Data register path, length chosen by the active instruction
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dr <= '0;
        end else if (ce && tckRise) begin
            if (state == ST_CAP_DR) begin
                dr <= '0;
                if (selBoundary(irReg)) begin
                    dr[BSR_LEN-1:0] <= pinLevel;
                end else if (irReg == OP_IDCODE) begin
                    dr[31:0] <= ID_VALUE;
                end else if (irReg == OP_USERCODE) begin
                    dr[31:0] <= userCode;
                end
            end else if (state == ST_SHF_DR) begin
                dr <= dr >> 1;
                dr[drLen(irReg)-1] <= tdiV;
            end
        end
    end

    // Update stage of the boundary chain
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bsrUpd <= '0;
        end else if (ce && tckRise && state == ST_UPD_DR) begin
            if (selBoundary(irReg)) begin
                bsrUpd <= dr[BSR_LEN-1:0];
            end
        end
    end

    // Pin drive: test pattern under EXTEST and CLAMP, core otherwise
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pinOut <= '0;
        end else if (ce) begin
            if (irReg == OP_EXTEST || irReg == OP_CLAMP) begin
                pinOut <= bsrUpd;
            end else begin
                pinOut <= coreOut;
            end
        end
    end

    // TDO changes on falling TCK, released outside shift states
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tdo <= 1'b1;
            tdoOe <= 1'b1;
            pinsReleased <= 1'b1;
        end else if (ce) begin
            pinsReleased <= !scanEnable;
            if (!scanEnable) begin
                tdoOe <= 1'b1;
            end else if (tckFall) begin
                if (state == ST_SHF_IR) begin
                    tdo <= irShift[0];
                    tdoOe <= 1'b0;
                end else if (state == ST_SHF_DR) begin
                    tdo <= dr[0];
                    tdoOe <= 1'b0;
                end else begin
                    tdoOe <= 1'b1;
                end
            end
        end
    end

    // Programming mode entry, exit and bulk erase timing
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            timer <= '0;
            switching <= 1'b0;
            progMode <= 1'b0;
            progBusy <= 1'b0;
            eraseActive <= 1'b0;
        end else if (ce) begin
            if (timer != 32'h0000_0000) begin
                timer <= timer - 32'h0000_0001;
                if (timer == 32'h0000_0001) begin
                    progBusy <= 1'b0;
                    eraseActive <= 1'b0;
                    switching <= 1'b0;
                end
            end else if (tckRise && state == ST_UPD_IR && !progBusy) begin
                if (irShift == OP_PROG_ENTER && !progMode) begin
                    progMode <= 1'b1;
                    switching <= 1'b1;
                    progBusy <= 1'b1;
                    timer <= 32'(SWITCH_CYC);
                end else if (irShift == OP_PROG_EXIT && progMode) begin
                    progMode <= 1'b0;
                    switching <= 1'b1;
                    progBusy <= 1'b1;
                    timer <= 32'(SWITCH_CYC);
                end else if (irShift == OP_BULK_ERASE && progMode) begin
                    eraseActive <= 1'b1;
                    progBusy <= 1'b1;
                    timer <= 32'(ERASE_CYCLES);
                end
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_IR_CAPTURE: assert property (
        ce && scanEnable && tckRise && state == ST_CAP_IR |=> irShift == IR_CAPTURE)
        else $error("instruction capture value wrong");
    AST_USER_CAPTURE: assert property (
        ce && scanEnable && tckRise && state == ST_CAP_DR && irReg == OP_USERCODE
        |=> dr[31:0] == $past(userCode))
        else $error("user code not captured");
    AST_SAMPLE_KEEPS_CORE: assert property (
        ce && irReg == OP_SAMPLE |=> pinOut == $past(coreOut))
        else $error("sample disturbed core outputs");
    AST_EXTEST_DRIVE: assert property (
        ce && irReg == OP_EXTEST |=> pinOut == $past(bsrUpd))
        else $error("extest pins not from update stage");
    AST_BYPASS_ZERO: assert property (
        ce && scanEnable && tckRise && state == ST_CAP_DR && irReg == OP_BYPASS
        |=> dr[0] == 1'b0)
        else $error("bypass bit not cleared on capture");
    AST_CLAMP_HOLD: assert property (
        ce && irReg == OP_CLAMP |=> pinOut == $past(bsrUpd))
        else $error("clamp pins not held");
    AST_ID_CAPTURE: assert property (
        ce && scanEnable && tckRise && state == ST_CAP_DR && irReg == OP_IDCODE
        |=> dr[31:0] == ID_VALUE && dr[0] == 1'b1)
        else $error("identification not captured");
    AST_TDO_RELEASE: assert property (
        ce && scanEnable && tckFall && state != ST_SHF_DR && state != ST_SHF_IR
        |=> tdoOe)
        else $error("tdo driven outside shift");
    AST_RELEASE_PINS: assert property (
        ce && !scanEnable |=> pinsReleased && tdoOe && state == ST_RESET)
        else $error("test pins not released");
    AST_ERASE_HOLD: assert property (
        $rose(eraseActive) |-> progBusy && progMode && timer > 32'h0000_0000)
        else $error("erase pulse without busy");
    AST_PROG_ENTRY: assert property (
        ce && tckRise && state == ST_UPD_IR && timer == 32'h0000_0000
        && irShift == OP_PROG_ENTER && !progMode
        |=> progMode && progBusy && switching && timer == 32'(SWITCH_CYC))
        else $error("programming entry not timed");
endmodule : bstp_test_port

//--- bstp_pkg.sv
// Shared constants and types for the boundary-scan test port
package bstp_pkg;
    localparam int IR_LEN = 10;
    localparam int UC_LEN = 32;
    localparam int ID_LEN = 32;
    // Instruction codes
    localparam logic [9:0] OP_EXTEST = 10'h000;
    localparam logic [9:0] OP_SAMPLE = 10'h005;
    localparam logic [9:0] OP_IDCODE = 10'h059;
    localparam logic [9:0] OP_USERCODE = 10'h007;
    localparam logic [9:0] OP_CLAMP = 10'h00A;
    localparam logic [9:0] OP_PROG_ENTER = 10'h2CC;
    localparam logic [9:0] OP_PROG_EXIT = 10'h201;
    localparam logic [9:0] OP_BULK_ERASE = 10'h2F2;
    localparam logic [9:0] OP_BYPASS = 10'h3FF;
    localparam logic [9:0] IR_CAPTURE = 10'h001;
    // Identification field positions
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFG_LSB = 1;
    // Arbitrary identity values
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h00A5;
    localparam logic [10:0] ID_MFG = 11'h012;
    localparam int BSR_DEFAULT = 96;
    // Timing
    localparam int CLK_MHZ = 250;
    localparam int PROG_SWITCH_US = 1000;
    localparam int ERASE_US = 100000;
    localparam int PROG_SWITCH_CYC = PROG_SWITCH_US * CLK_MHZ;
    localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
    localparam logic [2:0] SYNC_RESET = 3'h1;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bstp_pins_t;

    typedef enum logic [3:0] {
        ST_RESET = 4'b0000, ST_IDLE = 4'b0001, ST_SEL_DR = 4'b0010,
        ST_CAP_DR = 4'b0011, ST_SHF_DR = 4'b0100, ST_EX1_DR = 4'b0101,
        ST_PAU_DR = 4'b0110, ST_EX2_DR = 4'b0111, ST_UPD_DR = 4'b1000,
        ST_SEL_IR = 4'b1001, ST_CAP_IR = 4'b1010, ST_SHF_IR = 4'b1011,
        ST_EX1_IR = 4'b1100, ST_PAU_IR = 4'b1101, ST_EX2_IR = 4'b1110,
        ST_UPD_IR = 4'b1111
    } bstp_state_t;
endpackage : bstp_pkg

//--- bstp_link_model.sv
// Link-side test controller model that drives the test port pins
`timescale 1ns/1ps
module bstp_link_model (
    output bstp_pkg::bstp_pins_t pins,
    input wire logic tdo,
    input wire logic tdoOe
);
    import bstp_pkg::*;
    // Clock stays low between frames
    initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    // One link period: tms and tdi set while low, tdo taken just before the rise
    task automatic step(input logic tms, input logic tdi, output logic seen);
        pins.tms = tms;
        pins.tdi = tdi;
        #32;
        // A released tdo reads as the inverse of its last value
        seen = tdoOe ? ~tdo : tdo;
        pins.tck = 1'b1;
        #32;
        pins.tck = 1'b0;
    endtask : step
    // Outside shift states tdi carries no data, so it toggles
    task automatic walk(input logic tms);
        logic s;
        step(tms, ~pins.tdi, s);
    endtask : walk
    task automatic tap_reset();
        repeat (5) walk(1'b1);
        walk(1'b0);
    endtask : tap_reset
    // Idle to idle; ir picks the instruction path, data goes LSB first
    task automatic scan(input logic ir, input int len, input logic [127:0] din,
        output logic [127:0] dout);
        dout = '0;
        walk(1'b1);
        if (ir) walk(1'b1);
        walk(1'b0);
        walk(1'b0);
        for (int i = 0; i < len; i++) step(i == len - 1, din[i], dout[i]);
        walk(1'b1);
        walk(1'b0);
    endtask : scan
endmodule : bstp_link_model

//--- tb_boundary_scan_test_port.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module tb_boundary_scan_test_port;
    import bstp_pkg::*;
    localparam int BL = 96;
    localparam int SW = 20;
    localparam int ER = 50;
    localparam logic [31:0] ID_EXP = {ID_VERSION, ID_PART, ID_MFG, 1'b1};
    localparam logic [95:0] PA = {3{32'h1234_ABCD}};
    localparam logic [95:0] PB = {3{32'hF0E1_5A69}};
    localparam logic [95:0] PC = {3{32'h0FF0_C33C}};
    localparam logic [95:0] PD = {3{32'h8421_7E18}};
    logic mclk;
    logic resetn;
    logic ce;
    logic scanEnable;
    bstp_pins_t pins;
    logic [31:0] userCode;
    logic [BL-1:0] pinIn;
    logic [BL-1:0] coreOut;
    logic [BL-1:0] pinOut;
    logic tdo, tdoOe, pinsReleased, progMode, progBusy, eraseActive;
    logic [127:0] dout;
    int mismatches = 0;
    int tests_run = 0;
    int busyCnt = 0;
    int eraseCnt = 0;

    bstp_test_port #(.BSR_LEN(BL), .SWITCH_CYC(SW), .ERASE_CYCLES(ER)) dut (
        .mclk(mclk), .resetn(resetn), .ce(ce), .scanEnable(scanEnable), .pins(pins),
        .userCode(userCode), .pinIn(pinIn), .coreOut(coreOut), .tdo(tdo), .tdoOe(tdoOe),
        .pinsReleased(pinsReleased), .pinOut(pinOut), .progMode(progMode),
        .progBusy(progBusy), .eraseActive(eraseActive));
    bstp_link_model link (.pins(pins), .tdo(tdo), .tdoOe(tdoOe));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (progBusy === 1'b1) busyCnt++;
        if (eraseActive === 1'b1) eraseCnt++;
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic ir(input logic [9:0] code);
        link.scan(1'b1, 10, 128'(code), dout);
    endtask : ir

    task automatic test_reset();
        check(tdoOe, 1'b1);
        check(pinsReleased, 1'b1);
        check(progMode, 1'b0);
    endtask : test_reset
    task automatic test_ir_idcode();
        link.scan(1'b0, 32, 128'h0, dout);
        check(dout[31:0], ID_EXP);
        check(dout[0], 1'b1);
        check(tdoOe, 1'b1);
        // Twenty bits through a ten-bit register: the first ten reappear
        link.scan(1'b1, 20, {108'h0, OP_USERCODE, 10'h155}, dout);
        check(dout[9:0], IR_CAPTURE);
        check(dout[19:10], 10'h155);
        userCode = 32'hC0DE_5A17;
        link.scan(1'b0, 32, 128'h0, dout);
        check(dout[31:0], 32'hC0DE_5A17);
        link.tap_reset();
        link.scan(1'b0, 32, 128'h0, dout);
        check(dout[31:0], ID_EXP);
    endtask : test_ir_idcode
    task automatic test_bypass();
        ir(OP_BYPASS);
        link.scan(1'b0, 8, 128'hA5, dout);
        check(dout[7:0], 8'h4A);
        ir(10'h3C3);
        link.scan(1'b0, 8, 128'h96, dout);
        check(dout[7:0], 8'h2C);
    endtask : test_bypass
    task automatic test_boundary();
        pinIn = PA;
        coreOut = PB;
        ir(OP_SAMPLE);
        link.scan(1'b0, BL, 128'(PC), dout);
        check(dout[BL-1:0], PA);
        check(pinOut, PB);
        pinIn = PD;
        ir(OP_EXTEST);
        cyc(2);
        check(pinOut, PC);
        link.scan(1'b0, BL, 128'(PA), dout);
        check(dout[BL-1:0], PD);
        check(pinOut, PA);
        ir(OP_CLAMP);
        link.scan(1'b0, 8, 128'h3C, dout);
        check(dout[7:0], 8'h78);
        check(pinOut, PA);
        ir(OP_BYPASS);
        cyc(2);
        check(pinOut, PB);
    endtask : test_boundary
    task automatic test_programming();
        busyCnt = 0;
        ir(OP_PROG_ENTER);
        check(progMode, 1'b1);
        cyc(40);
        check(128'(busyCnt), 128'(SW));
        busyCnt = 0;
        eraseCnt = 0;
        ir(OP_BULK_ERASE);
        cyc(80);
        check(128'(eraseCnt), 128'(ER));
        check(128'(busyCnt), 128'(ER));
        busyCnt = 0;
        ir(OP_PROG_EXIT);
        cyc(40);
        check(progMode, 1'b0);
        check(128'(busyCnt), 128'(SW));
    endtask : test_programming
    task automatic test_release();
        scanEnable = 1'b0;
        cyc(3);
        check(pinsReleased, 1'b1);
        check(tdoOe, 1'b1);
        scanEnable = 1'b1;
        cyc(3);
        check(pinsReleased, 1'b0);
        link.tap_reset();
        link.scan(1'b0, 32, 128'h0, dout);
        check(dout[31:0], ID_EXP);
    endtask : test_release
    // With the clock enable low, a release request must not reach the port
    task automatic test_clock_enable();
        ce = 1'b0;
        scanEnable = 1'b0;
        cyc(3);
        check(pinsReleased, 1'b0);
        check(tdoOe, 1'b1);
        scanEnable = 1'b1;
        ce = 1'b1;
        cyc(3);
        link.scan(1'b0, 32, 128'h0, dout);
        check(dout[31:0], ID_EXP);
    endtask : test_clock_enable

    initial begin
        #200us;
        mismatches++;
        finish_test();
    end
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        scanEnable = 1'b1;
        userCode = 32'h0000_0000;
        pinIn = '0;
        coreOut = '0;
        repeat (10) @(posedge mclk);
        #1;
        test_reset();
        resetn = 1'b1;
        cyc(5);
        link.tap_reset();
        test_ir_idcode();
        test_bypass();
        test_boundary();
        test_programming();
        test_release();
        test_clock_enable();
        finish_test();
    end
endmodule : tb_boundary_scan_test_port
